// ### bench/ee_port_asserts.sv
// pin checker for the serial memory link between the two ends
`timescale 1ns/1ps
module ee_port_asserts #(
    parameter int unsigned PROG_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic chip_select,
    input wire logic program_enable_input,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic prog_busy,
    input wire logic write_enabled
);
    logic [31:0] busy_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // self-timed cycle length, counted: far too long to unroll
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= prog_busy ? busy_cnt + 32'h1 : 32'h0;
        end
    end
    property p_float_idle;
        !chip_select [*4] |-> !serial_out_en;
    endproperty
    a_float_idle: assert property (p_float_idle)
        else $error("data out driven while deselected");
    property p_drive_sel;
        $rose(serial_out_en) |-> chip_select;
    endproperty
    a_drive_sel: assert property (p_drive_sel)
        else $error("data out enabled without select");
    property p_busy_low;
        prog_busy && serial_out_en |-> !serial_out;
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("status not low while busy");
    property p_start_latch;
        $rose(prog_busy) |-> write_enabled;
    endproperty
    a_start_latch: assert property (p_start_latch)
        else $error("programming started while disabled");
    property p_start_pgm;
        $rose(prog_busy) |-> program_enable_input;
    endproperty
    a_start_pgm: assert property (p_start_pgm)
        else $error("programming started with program enable low");
    property p_cycle_len;
        busy_cnt <= PROG_CYCLES;
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("self-timed cycle overran");
    property p_start_desel;
        $rose(prog_busy) |-> !chip_select;
    endproperty
    a_start_desel: assert property (p_start_desel)
        else $error("programming started while selected");
    property p_latch_busy;
        $changed(write_enabled) |-> !$past(prog_busy);
    endproperty
    a_latch_busy: assert property (p_latch_busy)
        else $error("enable latch changed during programming");
    // main scenarios reached
    cover property ($rose(prog_busy));
    cover property ($rose(serial_out_en));
    cover property ($rose(write_enabled));
endmodule

// ### bench/serial_eeprom_three_wire_port_test.sv
// bench: controller and memory joined, driven over the register bus
`timescale 1ns/1ps
`include "ee_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module serial_eeprom_three_wire_port_test;
    logic ref_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, busy, wen, rerr;
    int miscompares = 0, num_checks = 0;
    ee_if ee_if_inst();
    ee_dev #(.PROG_CYCLES(50)) ee_dev_inst(.ref_clk(ref_clk), .rst(rst),
        .bus(ee_if_inst), .prog_busy(busy), .write_enabled(wen));
    ee_host #(.PWRUP_CYCLES(20)) ee_host_inst(.ref_clk(ref_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(ee_if_inst));
    ee_port_asserts #(.PROG_CYCLES(50)) ee_port_asserts_inst(
        .ref_clk(ref_clk), .rst(rst), .chip_select(ee_if_inst.chip_select),
        .program_enable_input(ee_if_inst.program_enable_input),
        .serial_out(ee_if_inst.serial_out),
        .serial_out_en(ee_if_inst.serial_out_en),
        .prog_busy(busy), .write_enabled(wen));
    task finish_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one bus transfer; held until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin miscompares++; finish_test; end
    endtask
    // issue a command and poll status; a frame takes ~2000 cycles
    task cmd(input logic [10:0] a, input logic [1:0] op);
        int n;
        apb(1'b1, `EE_REG_CMD, {19'h0, a, op});
        n = 0;
        do begin
            apb(1'b0, `EE_REG_STATUS, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 3000);
        if (n >= 3000) begin miscompares++; finish_test; end
    endtask
    task wr(input logic [10:0] a, input logic [15:0] d);
        apb(1'b1, `EE_REG_WDATA, {16'h0, d});
        cmd(a, `EE_OP_WRITE);
    endtask
    task chk_rd(input logic [10:0] a, input logic [15:0] e);
        cmd(a, `EE_OP_READ);
        apb(1'b0, `EE_REG_RDATA, 32'h0);
        `CHK(rdat, {16'h0, e})
    endtask
    task t_protect;
        `CHK(wen, 1'b0)
        cmd(11'h300, `EE_OP_EXT);
        `CHK(wen, 1'b1)
        cmd(11'h200, `EE_OP_EXT);
        chk_rd(11'h005, 16'hFFFF);
        cmd(11'h000, `EE_OP_EXT);
        `CHK(wen, 1'b0)
        wr(11'h005, 16'h1234);
        chk_rd(11'h005, 16'hFFFF);
        $display("test protect done");
    endtask
    task t_word;
        cmd(11'h300, `EE_OP_EXT);
        wr(11'h005, 16'h1234);
        apb(1'b0, `EE_REG_STATUS, 32'h0);
        `CHK(rdat[1:0], 2'b10)
        chk_rd(11'h005, 16'h1234);
        cmd(11'h005, `EE_OP_ERASE);
        chk_rd(11'h005, 16'hFFFF);
        $display("test word done");
    endtask
    // program enable low: latch commands still act, programming does not
    task t_pe;
        apb(1'b1, `EE_REG_CFG, 32'h1);
        wr(11'h005, 16'h4321);
        cmd(11'h000, `EE_OP_EXT);
        `CHK(wen, 1'b0)
        cmd(11'h300, `EE_OP_EXT);
        `CHK(wen, 1'b1)
        chk_rd(11'h005, 16'hFFFF);
        apb(1'b1, `EE_REG_CFG, 32'h3);
        $display("test program enable done");
    endtask
    task t_width;
        apb(1'b1, `EE_REG_WDATA, 32'hA5C3);
        cmd(11'h100, `EE_OP_EXT);
        chk_rd(11'h3FF, 16'hA5C3);
        apb(1'b1, `EE_REG_CFG, 32'h2);
        chk_rd(11'h7FE, 16'h00A5);
        wr(11'h003, 16'h005A);
        apb(1'b1, `EE_REG_CFG, 32'h3);
        chk_rd(11'h001, 16'hA55A);
        $display("test width done");
    endtask
    task t_regs;
        apb(1'b0, 12'h020, 32'h0);
        `CHK(rerr, 1'b1)
        `CHK(rdat, 32'h0)
        `CHK(ee_if_inst.serial_out_en, 1'b0)
        $display("test registers done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_protect;
        t_word;
        t_pe;
        t_width;
        t_regs;
        finish_test;
    end
endmodule

// ### design/ee_defs.svh
// constants for the three-wire serial memory port and its controller
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH
`define EE_CLK_NS 8
`define EE_PROG_MS 5
`define EE_PROG_CYC (`EE_PROG_MS * 1000000 / `EE_CLK_NS)
`define EE_CSMIN_NS 250
`define EE_CSMIN_CYC ((`EE_CSMIN_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_SKHALF_NS 250
`define EE_SKHALF_CYC ((`EE_SKHALF_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_PWRUP_MS 1
`define EE_PWRUP_CYC ((`EE_PWRUP_MS * 1000000 + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_PCNT_W 20
`define EE_PWR_W 17
`define EE_MEM_BYTES 2048
`define EE_CMD16_LAST 5'h0B
`define EE_CMD8_LAST 5'h0C
`define EE_DW16_LAST 5'h0F
`define EE_DW8_LAST 5'h07
`define EE_FR16_LAST 5'h0C
`define EE_FR16D_LAST 5'h1C
`define EE_FR8_LAST 5'h0D
`define EE_FR8D_LAST 5'h15
`define EE_ERASED 8'hFF
`define EE_OP_EXT 2'h0
`define EE_OP_WRITE 2'h1
`define EE_OP_READ 2'h2
`define EE_OP_ERASE 2'h3
`define EE_EXT_DIS 2'h0
`define EE_EXT_WRITE_ALL_CMD 2'h1
`define EE_EXT_ERASE_ALL_CMD 2'h2
`define EE_EXT_EN 2'h3
`define EE_REG_CMD 12'h000
`define EE_REG_WDATA 12'h004
`define EE_REG_STATUS 12'h008
`define EE_REG_RDATA 12'h00C
`define EE_REG_CFG 12'h010
`define EE_CMD_OP 1:0
`define EE_CMD_ADDR 12:2
`define EE_CFG_WIDE 0
`define EE_CFG_PROG 1
`endif

// ### design/ee_dev.sv
// serial memory end: frame decode, reads, self-timed programming
`timescale 1ns/1ps
`include "ee_defs.svh"
module ee_dev
    import ee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `EE_PROG_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    ee_if.dev bus,
    output logic prog_busy,
    output logic write_enabled
);
    ee_dev_t s;
    ee_dev_t next_s;
    logic [7:0] mem [`EE_MEM_BYTES];

    // one word as seen by the reader in the selected width
    function automatic logic [15:0] word_at(input logic [10:0] a,
                                            input logic w);
        if (w) begin
            word_at = {mem[{a[9:0], 1'b0}], mem[{a[9:0], 1'b1}]};
        end else begin
            word_at = {8'h00, mem[a]};
        end
    endfunction

    logic cs;
    logic sc;
    logic si;
    logic pgm;
    logic wide;
    logic rise;
    logic fall;
    logic allowed;
    logic [12:0] full;
    logic [1:0] op;
    logic [1:0] ext;
    logic [10:0] a;
    logic [10:0] a_next;
    logic [4:0] cmd_last;
    logic [4:0] dat_last;

    // pins pass two flops before use; only the second stage is read
    always_comb begin
        next_s = s;
        next_s.commit = 1'b0;
        next_s.cs_m = {s.cs_m[0], bus.chip_select};
        next_s.sc_m = {s.sc_m[0], bus.serial_clock};
        next_s.si_m = {s.si_m[0], bus.serial_in};
        next_s.pgm_m = {s.pgm_m[0], bus.program_enable_input};
        next_s.ww_m = {s.ww_m[0], bus.word_width_select};
        cs = s.cs_m[1];
        sc = s.sc_m[1];
        si = s.si_m[1];
        pgm = s.pgm_m[1];
        wide = s.ww_m[1];
        rise = sc & ~s.sc_prev;
        fall = ~sc & s.sc_prev;
        next_s.sc_prev = sc;
        next_s.cs_prev = cs;
        allowed = s.wen & pgm;
        full = {s.sr[11:0], si};
        cmd_last = wide ? `EE_CMD16_LAST : `EE_CMD8_LAST;
        dat_last = wide ? `EE_DW16_LAST : `EE_DW8_LAST;
        op = wide ? full[11:10] : full[12:11];
        ext = wide ? full[9:8] : full[10:9];
        a = wide ? {1'b0, full[9:0]} : full[10:0];
        // x16 addresses wrap within ten bits, x8 within eleven
        a_next = wide ? {1'b0, s.addr[9:0] + 10'h001}
                      : s.addr + 11'h001;

        // self-timed countdown runs on the system clock alone
        if (s.busy) begin
            if (s.pcnt == '0) begin
                next_s.busy = 1'b0;
                next_s.commit = 1'b1;
            end else begin
                next_s.pcnt = s.pcnt - 1'b1;
            end
        end

        if (!cs) begin
            next_s.st = D_IDLE;
            next_s.doe = 1'b0;
            next_s.stat_end = 1'b0;
            // a dummy one ends status even when select drops with its
            // falling clock, otherwise status would reappear later
            if (s.stat_end) begin
                next_s.stat = 1'b0;
            end
            // falling select after a complete frame starts the cycle
            if (s.cs_prev && s.st == D_DONE && s.pend != P_NONE
                    && !s.busy) begin
                next_s.busy = 1'b1;
                next_s.pcnt = `EE_PCNT_W'(PROG_CYCLES - 1);
                next_s.stat = 1'b1;
            end
        end else begin
            // status shows on the pin while selected after a cycle
            if (s.stat) begin
                next_s.doe = 1'b1;
                next_s.dout = ~s.busy;
                if (rise && si) begin
                    next_s.stat_end = 1'b1;
                end
                if (fall && s.stat_end) begin
                    next_s.stat = 1'b0;
                    next_s.stat_end = 1'b0;
                    next_s.doe = 1'b0;
                end
            end
            case (s.st)
                D_IDLE: begin
                    // zeros before the start bit are ignored
                    if (rise && si && !s.busy) begin
                        next_s.st = D_CMD;
                        next_s.cnt = '0;
                        next_s.sr = '0;
                        next_s.pend = P_NONE;
                    end
                end
                D_CMD: begin
                    if (rise) begin
                        next_s.sr = full;
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == cmd_last) begin
                            next_s.addr = a;
                            next_s.cnt = '0;
                            next_s.wd = '0;
                            next_s.st = D_DONE;
                            case (op)
                                `EE_OP_READ: begin
                                    next_s.st = D_READ;
                                    next_s.doe = 1'b1;
                                    next_s.dout = 1'b0;
                                    next_s.rsr = word_at(a, wide);
                                end
                                `EE_OP_WRITE: begin
                                    next_s.st = D_WDATA;
                                    next_s.pend = allowed ? P_WRITE
                                                          : P_NONE;
                                end
                                `EE_OP_ERASE: begin
                                    next_s.pend = allowed ? P_ERASE
                                                          : P_NONE;
                                end
                                default: begin
                                    case (ext)
                                        `EE_EXT_EN: next_s.wen = 1'b1;
                                        `EE_EXT_DIS: next_s.wen = 1'b0;
                                        `EE_EXT_ERASE_ALL_CMD: begin
                                            next_s.pend = allowed ? P_ERASE_ALL_CMD
                                                                  : P_NONE;
                                        end
                                        default: begin
                                            next_s.st = D_WDATA;
                                            next_s.pend = allowed ? P_WRITE_ALL_CMD
                                                                  : P_NONE;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                D_WDATA: begin
                    if (rise) begin
                        next_s.wd = {s.wd[14:0], si};
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == dat_last) begin
                            next_s.st = D_DONE;
                        end
                    end
                end
                D_READ: begin
                    // each bit leaves on a rising clock, msb first
                    if (rise) begin
                        next_s.dout = wide ? s.rsr[15] : s.rsr[7];
                        next_s.rsr = {s.rsr[14:0], 1'b0};
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == dat_last) begin
                            next_s.cnt = '0;
                            next_s.addr = a_next;
                            next_s.rsr = word_at(a_next, wide);
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // whole control state resets to idle and write-disabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // array keeps contents across reset, like the cells it models
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < `EE_MEM_BYTES; i++) begin
            if (s.commit && ((s.pend == P_ERASE_ALL_CMD || s.pend == P_WRITE_ALL_CMD)
                    || (s.ww_m[1] ? (11'(i) >> 1) == {1'b0, s.addr[9:0]}
                                  : 11'(i) == s.addr))) begin
                if (s.pend == P_ERASE || s.pend == P_ERASE_ALL_CMD) begin
                    mem[i] <= `EE_ERASED;
                end else if (s.ww_m[1] && i[0] == 1'b0) begin
                    mem[i] <= s.wd[15:8];
                end else begin
                    mem[i] <= s.wd[7:0];
                end
            end
        end
    end

    assign bus.serial_out = s.dout;
    assign bus.serial_out_en = s.doe;
    assign prog_busy = s.busy;
    assign write_enabled = s.wen;
endmodule

// ### design/ee_host.sv
// controller end: APB registers drive frames onto the serial pins
`timescale 1ns/1ps
`include "ee_defs.svh"
module ee_host
    import ee_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = `EE_PWRUP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ee_if.host bus
);
    ee_host_t s;
    ee_host_t next_s;
    logic tick;
    logic so;
    logic wr;
    logic [1:0] ext;
    logic [28:0] fr;

    always_comb begin
        next_s = s;
        next_s.so_m = {s.so_m[0], bus.serial_out_line};
        so = s.so_m[1];
        tick = (s.dcnt == '0);
        next_s.dcnt = tick ? 6'(`EE_SKHALF_CYC - 1) : s.dcnt - 1'b1;
        // no frame until the power-up wait has passed
        if (!s.pwr_ok) begin
            next_s.pwr = s.pwr + 1'b1;
            next_s.pwr_ok = (s.pwr == `EE_PWR_W'(PWRUP_CYCLES - 1));
        end

        // zero-wait slave: answer is prepared in the setup cycle
        next_s.pready = psel & ~penable;
        next_s.pslverr = 1'b0;
        next_s.prdata = '0;
        if (paddr == `EE_REG_CMD) begin
            next_s.prdata = {19'h00000, s.addr, s.op};
        end else if (paddr == `EE_REG_WDATA) begin
            next_s.prdata = {16'h0000, s.wd};
        end else if (paddr == `EE_REG_STATUS) begin
            next_s.prdata = {30'h00000000, s.ready,
                             s.go | (s.st != H_IDLE)};
        end else if (paddr == `EE_REG_RDATA) begin
            next_s.prdata = {16'h0000, s.rdata};
        end else if (paddr == `EE_REG_CFG) begin
            next_s.prdata = {30'h00000000, s.pgm, s.ww};
        end else begin
            next_s.pslverr = psel & ~penable;
        end
        wr = psel & penable & s.pready & pwrite;
        if (wr && paddr == `EE_REG_CMD && !s.go && s.st == H_IDLE) begin
            next_s.op = pwdata[`EE_CMD_OP];
            next_s.addr = pwdata[`EE_CMD_ADDR];
            next_s.go = 1'b1;
            next_s.ready = 1'b0;
        end else if (wr && paddr == `EE_REG_WDATA) begin
            next_s.wd = pwdata[15:0];
        end else if (wr && paddr == `EE_REG_CFG) begin
            next_s.ww = pwdata[`EE_CFG_WIDE];
            next_s.pgm = pwdata[`EE_CFG_PROG];
        end

        ext = s.ww ? s.addr[9:8] : s.addr[10:9];
        fr = s.ww ? {1'b1, s.op, s.addr[9:0], s.wd}
                  : {1'b1, s.op, s.addr, s.wd[7:0], 7'h00};
        case (s.st)
            H_IDLE: begin
                if (s.go && s.pwr_ok) begin
                    next_s.go = 1'b0;
                    next_s.is_read = (s.op == `EE_OP_READ);
                    next_s.is_prog = (s.op == `EE_OP_WRITE)
                        || (s.op == `EE_OP_ERASE)
                        || (s.op == `EE_OP_EXT && (ext == `EE_EXT_ERASE_ALL_CMD
                                                 || ext == `EE_EXT_WRITE_ALL_CMD));
                    wr = (s.op == `EE_OP_WRITE)
                        || (s.op == `EE_OP_EXT && ext == `EE_EXT_WRITE_ALL_CMD);
                    next_s.last = s.ww
                        ? (wr ? `EE_FR16D_LAST : `EE_FR16_LAST)
                        : (wr ? `EE_FR8D_LAST : `EE_FR8_LAST);
                    next_s.cs = 1'b1;
                    next_s.sin = fr[28];
                    next_s.frame = {fr[27:0], 1'b0};
                    next_s.bitcnt = '0;
                    next_s.rdata = '0;
                    next_s.dcnt = 6'(`EE_SKHALF_CYC - 1);
                    next_s.st = H_SHIFT;
                end
            end
            H_SHIFT: begin
                // data changes on the falling edge, memory takes it rising
                if (tick && !s.sclk) begin
                    next_s.sclk = 1'b1;
                end else if (tick) begin
                    next_s.sclk = 1'b0;
                    next_s.bitcnt = s.bitcnt + 1'b1;
                    next_s.sin = s.frame[28];
                    next_s.frame = {s.frame[27:0], 1'b0};
                    if (s.bitcnt == s.last) begin
                        next_s.bitcnt = '0;
                        next_s.sin = 1'b0;
                        next_s.st = s.is_read ? H_READ : H_GAP;
                        next_s.cs = s.is_read;
                        next_s.dcnt = s.is_read ? 6'(`EE_SKHALF_CYC - 1)
                                                : 6'(`EE_CSMIN_CYC - 1);
                    end
                end
            end
            H_READ: begin
                // sample half a period after the memory changed the bit
                if (tick && !s.sclk) begin
                    next_s.sclk = 1'b1;
                end else if (tick) begin
                    next_s.sclk = 1'b0;
                    next_s.rdata = {s.rdata[14:0], so};
                    next_s.bitcnt = s.bitcnt + 1'b1;
                    if (s.bitcnt == (s.ww ? `EE_DW16_LAST
                                          : `EE_DW8_LAST)) begin
                        next_s.cs = 1'b0;
                        next_s.dcnt = 6'(`EE_CSMIN_CYC - 1);
                        next_s.st = H_GAP;
                    end
                end
            end
            H_GAP: begin
                // select stays low long enough to start programming
                if (tick) begin
                    next_s.cs = s.is_prog;
                    next_s.st = s.is_prog ? H_POLL : H_IDLE;
                end
            end
            H_POLL: begin
                // status needs a few cycles to settle; check each half
                if (tick && so) begin
                    next_s.ready = 1'b1;
                    next_s.is_prog = 1'b0;
                    next_s.sin = 1'b1;
                    next_s.st = H_END;
                end
            end
            default: begin
                // one clock with a dummy one to float the status pin
                if (tick && !s.sclk) begin
                    next_s.sclk = 1'b1;
                end else if (tick) begin
                    next_s.sclk = 1'b0;
                    next_s.sin = 1'b0;
                    next_s.cs = 1'b0;
                    next_s.dcnt = 6'(`EE_CSMIN_CYC - 1);
                    next_s.st = H_GAP;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.ww <= 1'b1;
            s.pgm <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign bus.chip_select = s.cs;
    assign bus.serial_clock = s.sclk;
    assign bus.serial_in = s.sin;
    assign bus.program_enable_input = s.pgm;
    assign bus.word_width_select = s.ww;
endmodule

// ### design/ee_if.sv
// pins between the serial memory and its controller
`timescale 1ns/1ps
interface ee_if;
    logic chip_select;
    logic serial_clock;
    logic serial_in;
    logic program_enable_input;
    logic word_width_select;
    logic serial_out;
    logic serial_out_en;
    wire serial_out_line;
    // an undriven data-out line is pulled high, so a poll of a refused
    // programming frame reads ready at once instead of hanging
    assign serial_out_line = serial_out_en ? serial_out : 1'b1;
    modport dev (
        input chip_select, serial_clock, serial_in, program_enable_input,
        input word_width_select,
        output serial_out, serial_out_en
    );
    modport host (
        output chip_select, serial_clock, serial_in, program_enable_input,
        output word_width_select,
        input serial_out_line
    );
endinterface

// ### design/ee_pkg.sv
// types shared by the memory port and its controller
package ee_pkg;
`include "ee_defs.svh"
    typedef enum logic [2:0] {D_IDLE, D_CMD, D_WDATA, D_READ, D_DONE} ee_dst_t;
    typedef enum logic [2:0] {P_NONE, P_WRITE, P_ERASE, P_ERASE_ALL_CMD, P_WRITE_ALL_CMD}
        ee_pop_t;
    typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_READ, H_GAP, H_POLL, H_END}
        ee_hst_t;
    typedef struct packed {
        logic [1:0] cs_m;
        logic [1:0] sc_m;
        logic [1:0] si_m;
        logic [1:0] pgm_m;
        logic [1:0] ww_m;
        logic sc_prev;
        logic cs_prev;
        ee_dst_t st;
        logic [4:0] cnt;
        logic [12:0] sr;
        logic [15:0] wd;
        logic [10:0] addr;
        logic [15:0] rsr;
        logic wen;
        ee_pop_t pend;
        logic busy;
        logic [`EE_PCNT_W-1:0] pcnt;
        logic stat;
        logic stat_end;
        logic commit;
        logic dout;
        logic doe;
    } ee_dev_t;
    typedef struct packed {
        ee_hst_t st;
        logic ww;
        logic pgm;
        logic go;
        logic ready;
        logic is_prog;
        logic is_read;
        logic [1:0] op;
        logic [10:0] addr;
        logic [15:0] wd;
        logic [15:0] rdata;
        logic [28:0] frame;
        logic [4:0] last;
        logic [4:0] bitcnt;
        logic [5:0] dcnt;
        logic [`EE_PWR_W-1:0] pwr;
        logic pwr_ok;
        logic [1:0] so_m;
        logic cs;
        logic sclk;
        logic sin;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ee_host_t;
endpackage
